// file: flash_self_program_sequencer.sv
`timescale 1ns/1ps
// flash self-programming command sequencer
// the cpu loads command, pointers and write data, then halts;
// halt in self-programming mode starts the array operation
// and the cpu stays held until the result is in the status
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 16 // flash byte address width (block, offset)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // cpu side: register writes and halt
  input wire logic reg_wr_i, // cpu register write strobe
  input wire logic [3:0] reg_sel_i, // register select
  input wire logic [7:0] reg_wdata_i, // register write data
  input wire logic halt_i, // cpu executes halt (pulse)
  // array side and protection settings
  input wire logic [7:0] blk_protected_i, // per-block-group protect, from protect byte
  input wire logic [7:0] flash_rdata_i, // array read data
  input wire logic flash_done_i, // array operation complete (pulse)
  input wire logic flash_fail_i, // array reports verify failure with done
  // status, mode and cpu control
  output logic [7:0] flash_status_reg_o, // status register
  output logic [7:0] flash_command_reg_o, // command register
  output logic self_mode_o, // self-programming mode
  output logic cpu_hold_o, // holds the cpu while high
  output logic resume_o, // pulse: cpu resumes after halt
  // array requests
  output logic flash_erase_o, // pulse: erase block
  output logic flash_prog_o, // pulse: program byte
  output logic flash_rd_o, // pulse: read byte for blank check
  output logic [ADDR_W-1:0] flash_addr_o, // array address
  output logic [7:0] flash_wdata_o // array write data
);
  // one-hot command states:
  //   idle  - registers writable, waiting for halt
  //   issue - protection check, then one array pulse
  //   wait  - erase or program running in the array
  //   blank - one read per done until the compare address
  //   done  - release the cpu with a resume pulse
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ISSUE = 5'b00010,
    S_WAIT = 5'b00100,
    S_BLANK = 5'b01000,
    S_DONE = 5'b10000
  } sstate_t;
  // all sequencer state in one word: the cpu-visible registers,
  // the array request pulses and the latched address and data;
  // the pulses are cleared every cycle in the next-state logic
  typedef struct packed {
    sstate_t st;
    logic [7:0] cmd;
    logic [7:0] aph;
    logic [7:0] apl;
    logic [7:0] cmph;
    logic [7:0] cmpl;
    logic [7:0] wbuf;
    logic [7:0] stat;
    logic hold;
    logic resume;
    logic erase;
    logic prog;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } seq_t;
  // registered state and its next value
  seq_t s;
  seq_t next_s;
  // signals from the unlock checker and the protect lookup
  logic self_mode; // from unlock checker
  logic seq_err; // broken sequence pulse
  logic prot_hit; // target block is protected

  ////////////////////////////////////////////////////////////////
  // unlock sequence checker
  // it watches every register write, busy or not, and owns
  // the self-programming mode flag
  mode_unlock u_unlock (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(reg_wr_i),
    .sel_i(reg_sel_i),
    .data_i(reg_wdata_i),
    .self_mode_o(self_mode),
    .seq_err_o(seq_err)
  );

  // protection lookup on the block group of the high pointer;
  // only the low three bits pick a group, so blocks that differ
  // above bit 2 share one protect bit
  // (a user who needs finer protection must widen this input)
  assign prot_hit = blk_protected_i[s.aph[2:0]];

  ////////////////////////////////////////////////////////////////
  // register writes and the command state machine
  // cpu register writes land only while idle; while busy the
  // cpu is held, so a write then would be a software error
  always_comb begin
    next_s = s;
    // request pulses last exactly one cycle
    next_s.resume = 1'b0;
    next_s.erase = 1'b0;
    next_s.prog = 1'b0;
    next_s.rd = 1'b0;
    // cpu writes (cpu is stalled while busy, so no conflict)
    // the status write keeps only the three flag bits
    if (reg_wr_i && s.st == S_IDLE) begin
      case (reg_sel_i)
        SEL_CMD: next_s.cmd = reg_wdata_i;
        SEL_APH: next_s.aph = reg_wdata_i;
        SEL_APL: next_s.apl = reg_wdata_i;
        SEL_CMPH: next_s.cmph = reg_wdata_i;
        SEL_CMPL: next_s.cmpl = reg_wdata_i;
        SEL_WBUF: next_s.wbuf = reg_wdata_i;
        SEL_STAT: next_s.stat = reg_wdata_i & 8'h07;
        default: ;
      endcase
    end
    // a broken unlock sequence sets bit 0 one cycle after it
    // set wins over a clear in the same cycle
    if (seq_err) begin
      next_s.stat[SEQ_ERR_BIT] = 1'b1; // [R14]
    end
    case (s.st)
      S_IDLE: begin
        // launch only in self mode on a known command
        // address and data are latched here so that nothing
        // written later can disturb a running operation
        if (halt_i && self_mode && (s.cmd == CMD_ERASE || s.cmd == CMD_BLANK ||
            s.cmd == CMD_WRITE)) begin // [R16]
          next_s.hold = 1'b1; // [R8]
          next_s.addr = ADDR_W'({s.aph, s.apl});
          next_s.wdata = s.wbuf; // [R6]
          next_s.st = S_ISSUE;
        end else if (halt_i) begin
          next_s.resume = 1'b1; // ordinary halt release [R16]
        end
      end
      S_ISSUE: begin
        // a protected block gets no array pulse at all;
        // blank check only reads, so it skips the protection test
        if (prot_hit && s.cmd != CMD_BLANK) begin
          next_s.stat[PROTECT_ERR_BIT] = 1'b1; // [R9]
          next_s.st = S_DONE;
        end else if (s.cmd == CMD_ERASE) begin
          next_s.erase = 1'b1; // [R1]
          next_s.st = S_WAIT;
        end else if (s.cmd == CMD_WRITE) begin
          next_s.prog = 1'b1; // [R5] [R6]
          next_s.st = S_WAIT;
        end else begin
          next_s.rd = 1'b1; // [R3]
          next_s.st = S_BLANK;
        end
      end
      S_WAIT: begin
        // the array reports a verify failure together with done
        if (flash_done_i) begin
          if (flash_fail_i) begin
            next_s.stat[VERIFY_ERR_BIT] = 1'b1; // [R9]
          end
          next_s.st = S_DONE;
        end
      end
      S_BLANK: begin
        // each read is answered by one done with its data;
        // the first byte that is not erased ends the check
        if (flash_done_i) begin
          if (flash_rdata_i != ERASED_BYTE) begin
            next_s.stat[VERIFY_ERR_BIT] = 1'b1; // [R3] [R9]
            next_s.st = S_DONE;
          end else if (s.addr == ADDR_W'({s.cmph, s.cmpl})) begin
            next_s.st = S_DONE; // range end reached [R3]
          end else begin
            next_s.addr = s.addr + ADDR_W'(1);
            next_s.rd = 1'b1;
          end
        end
      end
      S_DONE: begin
        // status left untouched: zero means success [R10]
        // hold drops in the same cycle as the resume pulse
        next_s.hold = 1'b0;
        next_s.resume = 1'b1; // [R8]
        next_s.st = S_IDLE;
      end
      default: begin
        // an illegal state code falls back to idle
        next_s.st = S_IDLE;
      end
    endcase
  end

  // state register
  // reset clears every register, flag and request pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // asynchronous reset loads constants only
      s <= '{st: S_IDLE, cmd: REG_RESET, aph: REG_RESET, apl: REG_RESET,
             cmph: REG_RESET, cmpl: REG_RESET, wbuf: REG_RESET,
             stat: STATUS_RESET, hold: 1'b0, resume: 1'b0, erase: 1'b0,
             prog: 1'b0, rd: 1'b0, addr: '0, wdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs straight from state
  // every output is a register bit, so no combinational path
  // reaches the pins of the block
  assign flash_status_reg_o = s.stat;
  assign flash_command_reg_o = s.cmd;
  assign self_mode_o = self_mode;
  assign cpu_hold_o = s.hold;
  assign resume_o = s.resume;
  assign flash_erase_o = s.erase;
  assign flash_prog_o = s.prog;
  assign flash_rd_o = s.rd;
  assign flash_addr_o = s.addr;
  assign flash_wdata_o = s.wdata;
endmodule

// file: flash_seq_pkg.sv
// Summary of operation
// R1: command 03h erases block named by high pointer
// R2: erase: low ptr 00h, compares set by software
// R3: command 04h blank checks pointer-to-compare range
// R4: blank check: low ptr 00h, low compare ffh
// R5: command 05h writes one byte at pointers
// R6: byte write programs the write buffer value
// R7: software clears status before each operation
// R8: halt launches command, holds cpu, then resumes
// R9: status bit 1 verify, bit 2 protect error
// R10: status zero means normal termination
// R11: software kicks watchdog with ach before halt
// R12: after failed write, erase block and rewrite
// R13: a5h then 01h, feh, 01h enters self-program mode
// R14: status bit 0 flags a broken unlock sequence
// R15: a5h then 00h, ffh, 00h returns to normal
// R16: flash commands on halt only in self-program mode
package flash_seq_pkg;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_BLANK = 8'h04;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] PROT_KEY = 8'ha5;
  localparam logic [7:0] MODE_SELF = 8'h01;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int SEQ_ERR_BIT = 0;
  localparam int VERIFY_ERR_BIT = 1;
  localparam int PROTECT_ERR_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // register select codes of the cpu-side write port
  localparam logic [3:0] SEL_CMD = 4'h0;
  localparam logic [3:0] SEL_APH = 4'h1;
  localparam logic [3:0] SEL_APL = 4'h2;
  localparam logic [3:0] SEL_CMPH = 4'h3;
  localparam logic [3:0] SEL_CMPL = 4'h4;
  localparam logic [3:0] SEL_WBUF = 4'h5;
  localparam logic [3:0] SEL_STAT = 4'h6;
  localparam logic [3:0] SEL_PCMD = 4'h7;
  localparam logic [3:0] SEL_PMC = 4'h8;
endpackage

// file: mode_unlock.sv
`timescale 1ns/1ps
// protected mode-change sequence checker
module mode_unlock
  import flash_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i, // one-cycle write strobe
  input wire logic [3:0] sel_i, // register select
  input wire logic [7:0] data_i, // write data
  output logic self_mode_o, // self-programming mode active
  output logic seq_err_o // one-cycle pulse on a broken sequence
);
  typedef enum logic [3:0] {
    U_IDLE = 4'b0001,
    U_KEY = 4'b0010,
    U_INV = 4'b0100,
    U_LAST = 4'b1000
  } ustate_t;
  typedef struct packed {
    ustate_t st;
    logic [7:0] val;
    logic mode;
    logic err;
  } ulk_t;
  ulk_t s;
  ulk_t next_s;

  ////////////////////////////////////////////////////////////////
  // sequence: key, value, inverse, value; only the last one counts
  always_comb begin
    next_s = s;
    next_s.err = 1'b0;
    if (wr_i) begin
      case (s.st)
        U_IDLE: begin
          if (sel_i == SEL_PCMD && data_i == PROT_KEY) begin // [R13]
            next_s.st = U_KEY;
          end else if (sel_i == SEL_PMC) begin
            next_s.err = 1'b1; // [R14]
          end
        end
        U_KEY: begin
          if (sel_i == SEL_PMC) begin
            next_s.val = data_i;
            next_s.st = U_INV;
          end else begin
            next_s.err = 1'b1; // [R14]
            next_s.st = U_IDLE;
          end
        end
        U_INV: begin
          if (sel_i == SEL_PMC && data_i == ~s.val) begin // [R13] [R15]
            next_s.st = U_LAST;
          end else begin
            next_s.err = 1'b1; // [R14]
            next_s.st = U_IDLE;
          end
        end
        U_LAST: begin
          next_s.st = U_IDLE;
          if (sel_i == SEL_PMC && data_i == s.val &&
              (data_i == MODE_SELF || data_i == MODE_NORMAL)) begin
            next_s.mode = (data_i == MODE_SELF); // [R13] [R15]
          end else begin
            next_s.err = 1'b1; // [R14]
          end
        end
        default: begin
          next_s.st = U_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{st: U_IDLE, val: 8'h00, mode: 1'b0, err: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign self_mode_o = s.mode;
  assign seq_err_o = s.err;
endmodule

// file: flash_self_program_sequencer_assertions.sv
`timescale 1ns/1ps
// timing and status checks on the sequencer ports
module flash_seq_chk
  import flash_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic halt_i,
  input wire logic flash_done_i,
  input wire logic flash_fail_i,
  input wire logic [7:0] flash_status_reg_o,
  input wire logic [7:0] flash_command_reg_o,
  input wire logic self_mode_o,
  input wire logic cpu_hold_o,
  input wire logic resume_o,
  input wire logic flash_erase_o,
  input wire logic flash_prog_o,
  input wire logic flash_rd_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  hold_start_a: assert property ($rose(cpu_hold_o) |-> $past(halt_i) && self_mode_o)
    else $error("hold rose without a halt in self mode");
  normal_quiet_a: assert property (!self_mode_o |-> !(flash_erase_o | flash_prog_o))
    else $error("array command outside self mode");
  erase_cmd_a: assert property (flash_erase_o |-> flash_command_reg_o == CMD_ERASE)
    else $error("erase pulse with other command");
  prog_cmd_a: assert property (flash_prog_o |-> flash_command_reg_o == CMD_WRITE)
    else $error("program pulse with other command");
  blank_cmd_a: assert property (flash_rd_o |-> flash_command_reg_o == CMD_BLANK && cpu_hold_o)
    else $error("read pulse outside blank check");
  resume_free_a: assert property (resume_o |-> !cpu_hold_o ##1 !resume_o)
    else $error("resume overlaps hold or lasts");
  hold_end_a: assert property ($fell(cpu_hold_o) |-> resume_o)
    else $error("hold dropped without resume");
  done_resume_a: assert property (flash_done_i && cpu_hold_o && flash_command_reg_o != CMD_BLANK
    |-> ##2 resume_o)
    else $error("no resume two cycles after done");
  verify_set_a: assert property (flash_done_i && flash_fail_i && cpu_hold_o &&
    flash_command_reg_o != CMD_BLANK |-> ##2 flash_status_reg_o[VERIFY_ERR_BIT])
    else $error("verify flag not set on failure");
endmodule
bind flash_self_program_sequencer flash_seq_chk u_flash_seq_chk (.*);

// file: test_flash_self_program_sequencer.sv
`timescale 1ns/1ps
// self-checking bench for the flash sequencer
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_flash_self_program_sequencer
  import flash_seq_pkg::*;
;
  logic core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, halt_i = 0;
  logic flash_done_i = 0, flash_fail_i = 0, self_mode_o, cpu_hold_o, resume_o;
  logic flash_erase_o, flash_prog_o, flash_rd_o;
  logic [3:0] reg_sel_i = 0;
  logic [7:0] reg_wdata_i = 0, blk_protected_i = 0, flash_rdata_i = 0, wd;
  logic [7:0] flash_status_reg_o, flash_command_reg_o, flash_wdata_o;
  logic [15:0] flash_addr_o, addr;
  int err_count = 0, n_checks = 0, cyc = 0, n_rd, n_pl, n_hold;
  logic [7:0] rv = ERASED_BYTE; // byte the array answers a read with
  flash_self_program_sequencer u_flash_self_program_sequencer (.core_clk_i, .rst_n_i,
    .reg_wr_i, .reg_sel_i, .reg_wdata_i, .halt_i, .blk_protected_i, .flash_rdata_i,
    .flash_done_i, .flash_fail_i, .flash_status_reg_o, .flash_command_reg_o, .self_mode_o,
    .cpu_hold_o, .resume_o, .flash_erase_o, .flash_prog_o, .flash_rd_o, .flash_addr_o,
    .flash_wdata_o);
  ////////////////////////////////////////////////////////////////
  // clock and hang limit
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task end_of_test();
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one register write
  task wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_sel_i <= s;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task unlock(input logic [7:0] v);
    wr(SEL_PCMD, PROT_KEY);
    wr(SEL_PMC, v);
    wr(SEL_PMC, ~v);
    wr(SEL_PMC, v);
    @(posedge core_clk_i);
  endtask
  // command, pointers, compares, then status clear
  task setup(input logic [7:0] c, h, l, ch, cl);
    wr(SEL_CMD, c);
    wr(SEL_APH, h);
    wr(SEL_APL, l);
    wr(SEL_CMPH, ch);
    wr(SEL_CMPL, cl);
    wr(SEL_STAT, 8'h00);
    // no watchdog sits in this bench, so no kick precedes halt
  endtask
  // halt, answer every array pulse, stop at resume
  task op(input logic fl);
    int i;
    n_rd = 0;
    n_pl = 0;
    n_hold = 0;
    @(posedge core_clk_i);
    halt_i <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk_i);
      halt_i <= 1'b0;
      flash_done_i <= 1'b0;
      if (flash_erase_o | flash_prog_o | flash_rd_o) begin
        flash_done_i <= 1'b1;
        flash_fail_i <= fl;
        flash_rdata_i <= rv;
        n_pl++;
        n_rd += flash_rd_o;
        addr = flash_addr_o;
        wd = flash_wdata_o;
      end
      n_hold += cpu_hold_o;
      if (resume_o) break;
    end
    `CHK("resume", 1'b1, resume_o)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    `CHK("status", STATUS_RESET, flash_status_reg_o)
    setup(CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00);
    op(1'b0);
    `CHK("normal halt", 0, n_pl)
    `CHK("normal hold", 0, n_hold)
    wr(SEL_PCMD, PROT_KEY);
    wr(SEL_PMC, MODE_SELF);
    unlock(MODE_SELF);
    `CHK("seq err", 1'b1, flash_status_reg_o[SEQ_ERR_BIT])
    wr(SEL_STAT, 8'h00);
    unlock(MODE_SELF);
    `CHK("self mode", 1'b1, self_mode_o)
    setup(CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00);
    op(1'b0);
    `CHK("erase addr", 16'h0700, addr)
    `CHK("erase st", 8'h00, flash_status_reg_o)
    `CHK("erase hold", 4, n_hold)
    setup(CMD_WRITE, 8'h07, 8'h20, 8'h07, 8'h00);
    wr(SEL_WBUF, 8'h10);
    op(1'b1);
    `CHK("wr addr", 16'h0720, addr)
    `CHK("wr data", 8'h10, wd)
    `CHK("wr st", 8'h02, flash_status_reg_o)
    `CHK("wr cmd", CMD_WRITE, flash_command_reg_o)
    setup(CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00);
    op(1'b0);
    setup(CMD_WRITE, 8'h07, 8'h20, 8'h07, 8'h00);
    wr(SEL_WBUF, 8'h10);
    op(1'b0);
    `CHK("rewrite st", 8'h00, flash_status_reg_o)
    setup(CMD_BLANK, 8'h07, 8'h00, 8'h07, 8'hff);
    op(1'b0);
    `CHK("reads", 256, n_rd)
    `CHK("last rd", 16'h07ff, addr)
    `CHK("blank st", 8'h00, flash_status_reg_o)
    rv = 8'h5a;
    setup(CMD_BLANK, 8'h07, 8'h00, 8'h07, 8'hff);
    op(1'b0);
    rv = ERASED_BYTE;
    `CHK("dirty reads", 1, n_rd)
    `CHK("dirty st", 8'h02, flash_status_reg_o)
    blk_protected_i <= 8'h80;
    setup(CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00);
    op(1'b0);
    `CHK("prot pulses", 0, n_pl)
    `CHK("prot st", 8'h04, flash_status_reg_o)
    wr(SEL_STAT, 8'h00);
    unlock(MODE_NORMAL);
    `CHK("normal mode", 1'b0, self_mode_o)
    end_of_test();
  end
endmodule
